// *** design/pm_regs_pkg.sv ***
// Constants for the power-management configuration register bank
package pm_regs_pkg;

  // ***********************************
  // Configuration space layout
  // ***********************************
  localparam int CFG_ADDR_W = 8;
  localparam int CFG_DATA_W = 32;
  localparam int CFG_BE_W = 4;
  // Dword holding control/status, bridge extension and data report
  localparam logic [7:0] POWER_CONTROL_STATUS_OFS = 8'he0;
  localparam logic [7:0] BRIDGE_SUPPORT_EXTENSION_OFS = 8'he2;
  localparam logic [7:0] POWER_DATA_REPORT_OFS = 8'he3;
  localparam int DWORD_LSB = 2;

  // ***********************************
  // Field positions within the dword
  // ***********************************
  localparam int STATE_LSB = 0;
  localparam int STATE_MSB = 1;
  localparam int RSVD_LSB = 2;
  localparam int RSVD_MSB = 7;
  localparam int WAKE_ENABLE_BIT = 8;
  localparam int SELECT_LSB = 9;
  localparam int SELECT_MSB = 12;
  localparam int SCALE_LSB = 13;
  localparam int SCALE_MSB = 14;
  localparam int WAKE_FLAG_BIT = 15;
  localparam int BSE_LSB = 16;
  localparam int BSE_MSB = 23;
  localparam int LOW_POWER_SELECT_BIT = 22;
  localparam int CLOCK_CTL_ENABLE_BIT = 23;
  localparam int DATA_LSB = 24;
  localparam int DATA_MSB = 31;
  // Byte lane that carries the writable power-state field
  localparam int STATE_LANE = 0;

  // ***********************************
  // Reset and fixed values
  // ***********************************
  localparam logic [15:0] CSR_FIXED = 16'h0000;
  localparam logic [7:0] BSE_FIXED = 8'h00;
  localparam logic [7:0] DATA_FIXED = 8'h00;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // ***********************************
  // Power states
  // ***********************************
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_LIGHT = 2'b01,
    PWR_DEEP = 2'b10,
    PWR_DOWN = 2'b11
  } power_state_t;

  localparam power_state_t POWER_STATE_RESET = PWR_ACTIVE;

endpackage : pm_regs_pkg

// *** design/pm_regs.sv ***
// Power-management control/status registers in configuration space
// Contract
// - Two-bit read/write power-state field in control/status bits 1:0.
// - Code 00 means fully active, normal operation.
// - Writing code 11 powers down and stops the internal core clock.
// - Code 10 behaves exactly like normal operation, clocks running.
// - Wake event never asserted; its flag and enable bits read zero.
// - Data scaling field, bits 14:13, is read-only zero.
// - Data select field, bits 12:9, is read-only zero.
// - Bridge support extension register always reads zero.
// - Bus power/clock control enable bit 7 reads zero, read-only.
// - Secondary-bus low-power select bit 6 reads zero, read-only.
// - Power data report register is read-only and reads zero.
`timescale 1ns/1ps

module pm_regs
  import pm_regs_pkg::*;
(
  // Clock and PCI reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Configuration access
  input wire logic cfg_read_i,
  input wire logic cfg_write_i,
  input wire logic [pm_regs_pkg::CFG_ADDR_W-1:0] cfg_addr_i,
  input wire logic [pm_regs_pkg::CFG_BE_W-1:0] cfg_byte_en_i,
  input wire logic [pm_regs_pkg::CFG_DATA_W-1:0] cfg_wdata_i,
  output logic cfg_hit_o,
  output logic cfg_read_ack_o,
  output logic [pm_regs_pkg::CFG_DATA_W-1:0] cfg_rdata_o,
  // Power control towards the core
  output logic [1:0] power_state_o,
  output logic core_clock_enable_o,
  // Wake event pin, open drain
  output logic wake_event_out_o,
  output logic wake_event_oe_o
);
  import pm_regs_pkg::*;

  // Every check below samples on the PCI clock and sleeps in reset
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // ***********************************
  // Address decode
  // ***********************************
  localparam logic [CFG_ADDR_W-DWORD_LSB-1:0] PM_DWORD =
    POWER_CONTROL_STATUS_OFS[CFG_ADDR_W-1:DWORD_LSB];

  logic addr_hit;
  logic state_write;
  power_state_t power_state_q;
  power_state_t power_state_d;
  logic core_run_q;
  logic read_ack_q;
  logic [CFG_DATA_W-1:0] rdata_q;
  logic [CFG_DATA_W-1:0] read_value;

  assign addr_hit = (cfg_addr_i[CFG_ADDR_W-1:DWORD_LSB] == PM_DWORD);
  assign cfg_hit_o = addr_hit & (cfg_read_i | cfg_write_i);
  // Only the lane carrying bits 7:0 can change anything
  assign state_write = cfg_write_i & addr_hit &
    cfg_byte_en_i[STATE_LANE];

  // ***********************************
  // Power-state field
  // ***********************************
  always_comb
  begin
    power_state_d = power_state_q;
    if (state_write)
    begin
      power_state_d = power_state_t'(cfg_wdata_i[STATE_MSB:STATE_LSB]);
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      power_state_q <= POWER_STATE_RESET;
    end
    else
    begin
      power_state_q <= power_state_d;
    end
  end

  // ***********************************
  // Core clock gating enable
  // ***********************************
  // Decoded from the next state so the enable moves with the state register
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      core_run_q <= 1'b1;
    end
    else
    begin
      case (power_state_d)
        PWR_ACTIVE: core_run_q <= 1'b1;
        PWR_LIGHT: core_run_q <= 1'b1;
        PWR_DEEP: core_run_q <= 1'b1;
        PWR_DOWN: core_run_q <= 1'b0;
        default: core_run_q <= 1'b1;
      endcase
    end
  end

  assign power_state_o = power_state_q;
  assign core_clock_enable_o = core_run_q;

  // ***********************************
  // Wake event pin never driven
  // ***********************************
  assign wake_event_out_o = 1'b0;
  assign wake_event_oe_o = 1'b0;

  // ***********************************
  // Read path
  // ***********************************
  always_comb
  begin
    read_value = RDATA_IDLE;
    // Hard-wired fields: flag, enable, scale, select, reserved
    read_value[15:0] = CSR_FIXED;
    read_value[STATE_MSB:STATE_LSB] = power_state_q;
    read_value[BSE_MSB:BSE_LSB] = BSE_FIXED;
    read_value[DATA_MSB:DATA_LSB] = DATA_FIXED;
  end

  // Data is zero outside an acknowledge so it can be ORed onto a shared bus
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      read_ack_q <= 1'b0;
      rdata_q <= RDATA_IDLE;
    end
    else
    begin
      read_ack_q <= cfg_read_i & addr_hit;
      if (cfg_read_i & addr_hit)
      begin
        rdata_q <= read_value;
      end
      else
      begin
        rdata_q <= RDATA_IDLE;
      end
    end
  end

  assign cfg_read_ack_o = read_ack_q;
  assign cfg_rdata_o = rdata_q;

  // ***********************************
  // Power-state assertions
  // ***********************************

  state_write_takes_a: assert property (
    state_write |=> power_state_o == $past(cfg_wdata_i[1:0]))
    else $error("power state did not take written value");

  active_runs_a: assert property (
    power_state_o == 2'b00 |-> core_clock_enable_o)
    else $error("core clock stopped in active state");

  down_stops_a: assert property (
    state_write && cfg_wdata_i[1:0] == 2'b11 |=>
      !core_clock_enable_o && power_state_o == 2'b11)
    else $error("power down did not stop core clock");

  deep_runs_a: assert property (
    power_state_o == 2'b10 |-> core_clock_enable_o)
    else $error("core clock stopped in state 10");

  light_runs_a: assert property (
    power_state_o == 2'b01 |-> core_clock_enable_o)
    else $error("core clock stopped in state 01");

  clock_follows_a: assert property (
    core_clock_enable_o == (power_state_o != 2'b11))
    else $error("core clock enable out of step with state");

  down_holds_a: assert property (
    power_state_o == 2'b11 && !state_write |=> !core_clock_enable_o)
    else $error("core clock restarted while powered down");

  active_write_runs_a: assert property (
    state_write && cfg_wdata_i[1:0] == 2'b00 |=>
      core_clock_enable_o && power_state_o == 2'b00)
    else $error("active write did not run core clock");

  light_stored_a: assert property (
    state_write && cfg_wdata_i[1:0] == 2'b01 |=>
      core_clock_enable_o && power_state_o == 2'b01)
    else $error("state 01 not stored or clock stopped");

  deep_stored_a: assert property (
    state_write && cfg_wdata_i[1:0] == 2'b10 |=>
      core_clock_enable_o && power_state_o == 2'b10)
    else $error("state 10 not stored or clock stopped");

  state_holds_a: assert property (
    !state_write |=> $stable(power_state_o))
    else $error("power state changed without a write");

  read_in_down_a: assert property (
    power_state_o == 2'b11 && cfg_read_i && addr_hit |=> cfg_read_ack_o)
    else $error("read not answered while powered down");

  // ***********************************
  // Read-only field assertions
  // ***********************************

  wake_quiet_a: assert property (
    !wake_event_oe_o && !(cfg_read_ack_o &&
      (cfg_rdata_o[15] || cfg_rdata_o[8])))
    else $error("wake event driven or reported");

  scale_zero_a: assert property (
    cfg_read_ack_o |-> cfg_rdata_o[14:13] == 2'b00)
    else $error("data scale field not zero");

  select_zero_a: assert property (
    cfg_read_ack_o |-> cfg_rdata_o[12:9] == 4'h0)
    else $error("data select field not zero");

  bridge_zero_a: assert property (
    cfg_read_ack_o |-> cfg_rdata_o[23:16] == 8'h00)
    else $error("bridge extension not zero");

  clock_ctl_zero_a: assert property (
    cfg_read_ack_o |-> !cfg_rdata_o[23])
    else $error("bus clock control enable set");

  low_power_zero_a: assert property (
    cfg_read_ack_o |-> !cfg_rdata_o[22])
    else $error("secondary low power select set");

  data_report_zero_a: assert property (
    cfg_read_ack_o |-> cfg_rdata_o[31:24] == 8'h00)
    else $error("power data report not zero");

  wake_pin_low_a: assert property (
    !wake_event_out_o && !wake_event_oe_o)
    else $error("wake event pin driven");

  wake_bits_zero_a: assert property (
    cfg_read_ack_o |-> !cfg_rdata_o[15] && !cfg_rdata_o[8])
    else $error("wake flag or enable reads one");

  reserved_zero_a: assert property (
    cfg_read_ack_o |-> cfg_rdata_o[7:2] == 6'h00)
    else $error("reserved control bits not zero");

  // ***********************************
  // Access path assertions
  // ***********************************

  ro_write_ignored_a: assert property (
    cfg_write_i && !state_write |=> $stable(power_state_o))
    else $error("power state changed without lane 0 write");

  read_reflects_a: assert property (
    cfg_read_i && addr_hit && !cfg_write_i |=>
      cfg_read_ack_o && cfg_rdata_o[7:0] == {6'h00, $past(power_state_o)})
    else $error("read data does not match power state");

  lane_off_ignored_a: assert property (
    cfg_write_i && !cfg_byte_en_i[STATE_LANE] |=> $stable(power_state_o))
    else $error("write with lane 0 off changed power state");

  miss_no_ack_a: assert property (
    !(cfg_read_i && addr_hit) |=>
      !cfg_read_ack_o && cfg_rdata_o == RDATA_IDLE)
    else $error("acknowledge or data without a read");

  miss_no_hit_a: assert property (
    cfg_addr_i[7:2] != POWER_CONTROL_STATUS_OFS[7:2] |-> !cfg_hit_o)
    else $error("hit on a foreign address");

  hit_on_access_a: assert property (
    (cfg_read_i || cfg_write_i) &&
      cfg_addr_i[7:2] == POWER_CONTROL_STATUS_OFS[7:2] |-> cfg_hit_o)
    else $error("access to own dword not hit");

  ack_after_read_a: assert property (
    cfg_read_ack_o |-> $past(cfg_read_i))
    else $error("acknowledge without an earlier read");

  // ***********************************
  // Coverage
  // ***********************************

  enter_down_c: cover property (
    state_write && cfg_wdata_i[1:0] == 2'b11 ##1 !core_clock_enable_o);
  wake_up_c: cover property (
    !core_clock_enable_o ##1 core_clock_enable_o);
  read_in_down_c: cover property (
    power_state_o == 2'b11 && cfg_read_ack_o);
  light_state_c: cover property (power_state_o == 2'b01);
  refused_write_c: cover property (cfg_write_i && !cfg_byte_en_i[STATE_LANE]);

endmodule : pm_regs

// *** tb/pm_regs_tb.sv ***
// Self-checking testbench for the power-management register bank
`timescale 1ns/1ps

module pm_regs_tb;
  import pm_regs_pkg::*;

  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cfg_read_i = 1'b0;
  logic cfg_write_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [3:0] cfg_byte_en_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0000_0000;
  logic cfg_hit_o;
  logic cfg_read_ack_o;
  logic [31:0] cfg_rdata_o;
  logic [1:0] power_state_o;
  logic core_clock_enable_o;
  logic wake_event_out_o;
  logic wake_event_oe_o;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;

  pm_regs i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .cfg_read_i(cfg_read_i), .cfg_write_i(cfg_write_i),
    .cfg_addr_i(cfg_addr_i), .cfg_byte_en_i(cfg_byte_en_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_hit_o(cfg_hit_o),
    .cfg_read_ack_o(cfg_read_ack_o), .cfg_rdata_o(cfg_rdata_o),
    .power_state_o(power_state_o),
    .core_clock_enable_o(core_clock_enable_o),
    .wake_event_out_o(wake_event_out_o),
    .wake_event_oe_o(wake_event_oe_o));

  // ***********************************
  // Clock and hang guard
  // ***********************************
  initial
  begin
    forever #25 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      n_errors++;
      $display("[ERR] %0t run did not finish", $time);
      close_out();
    end
  end

  // ***********************************
  // Shared tasks
  // ***********************************
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    if (got !== exp)
      n_errors++;
  endtask : chk

  // Strobes stay high across back-to-back calls
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d);
    cfg_read_i = 1'b0;
    cfg_write_i = 1'b1;
    cfg_addr_i = a;
    cfg_byte_en_i = be;
    cfg_wdata_i = d;
    #1 chk(cfg_hit_o, a[7:2] == 6'h38);
    @(negedge clock_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic hit;
    hit = (a[7:2] == 6'h38);
    cfg_write_i = 1'b0;
    cfg_read_i = 1'b1;
    cfg_addr_i = a;
    #1 chk(cfg_hit_o, hit);
    @(negedge clock_i);
    chk(cfg_read_ack_o, hit);
    chk(cfg_rdata_o, hit ? exp : RDATA_IDLE);
  endtask : rd

  task automatic idle();
    cfg_write_i = 1'b0;
    cfg_read_i = 1'b0;
    @(negedge clock_i);
    chk(cfg_read_ack_o, 0);
    chk(cfg_rdata_o, RDATA_IDLE);
  endtask : idle

  task automatic chk_state(input logic [1:0] s);
    chk(power_state_o, s);
    chk(core_clock_enable_o, s != 2'b11);
    chk({wake_event_out_o, wake_event_oe_o}, 0);
  endtask : chk_state

  // ***********************************
  // Scenarios
  // ***********************************
  task automatic t_codes();
    for (int c = 0; c < 4; c++)
    begin
      wr(POWER_CONTROL_STATUS_OFS, 4'hf, 32'hffff_fffc | c);
      chk_state(c[1:0]);
      rd(BRIDGE_SUPPORT_EXTENSION_OFS, c);
      rd(POWER_DATA_REPORT_OFS, c);
      idle();
    end
  endtask : t_codes

  task automatic t_refuse();
    wr(POWER_CONTROL_STATUS_OFS, 4'he, 32'hffff_fffc);
    wr(8'he4, 4'hf, 32'hffff_fffc);
    rd(8'hdc, 0);
    idle();
    chk_state(2'b11);
  endtask : t_refuse

  task automatic t_back_to_back();
    wr(POWER_CONTROL_STATUS_OFS, 4'h1, 32'h0000_0001);
    chk_state(2'b01);
    wr(POWER_CONTROL_STATUS_OFS, 4'h1, 32'h0000_0000);
    rd(POWER_CONTROL_STATUS_OFS, 0);
    wr(POWER_CONTROL_STATUS_OFS, 4'h1, 32'h0000_0003);
    rd(POWER_CONTROL_STATUS_OFS, 3);
    idle();
    chk_state(2'b11);
  endtask : t_back_to_back

  task automatic t_reset_again();
    reset_n_i = 1'b0;
    @(negedge clock_i);
    chk_state(POWER_STATE_RESET);
    reset_n_i = 1'b1;
    @(negedge clock_i);
    chk_state(POWER_STATE_RESET);
    rd(POWER_CONTROL_STATUS_OFS, CSR_FIXED);
    idle();
  endtask : t_reset_again

  initial
  begin
    repeat (4) @(negedge clock_i);
    chk_state(POWER_STATE_RESET);
    reset_n_i = 1'b1;
    @(negedge clock_i);
    rd(POWER_CONTROL_STATUS_OFS, CSR_FIXED);
    idle();
    t_codes();
    t_refuse();
    t_back_to_back();
    t_reset_again();
    close_out();
  end

endmodule : pm_regs_tb
